// [hw/cssr_defs.vh]
// constants for the converter system status register pair
`ifndef CSSR_DEFS_VH
`define CSSR_DEFS_VH

// register offsets on the management port
`define CSSR_OFS_CONV_CFG       8'hDC
`define CSSR_OFS_PHASE_CFG      8'hDD

// reset values
`define CSSR_RST_CONV_CFG       8'h00
`define CSSR_RST_PHASE_CFG      8'h00

// converter_config_status fields
`define CSSR_CONV_DIR_BIT       0
`define CSSR_POS_LO             1
`define CSSR_POS_HI             2
`define CSSR_SWMODE_BIT         3
`define CSSR_PROT_BIT           4
`define CSSR_OUTSTYLE_BIT       5
`define CSSR_CONV_RSVD_BIT      6
`define CSSR_READY_BIT          7

// phase_config_status fields
`define CSSR_SHED_BIT           0
`define CSSR_OPPH_LO            1
`define CSSR_OPPH_HI            3
`define CSSR_MAXPH_LO           4
`define CSSR_MAXPH_HI           6
`define CSSR_PHASE_RSVD_BIT     7

// device position codes
`define CSSR_POS_MASTER         2'h0

// phase count codes
`define CSSR_OPPH_SIX           3'h7
`define CSSR_OPPH_FOUR          3'h5
`define CSSR_OPPH_THREE         3'h3
`define CSSR_OPPH_TWO           3'h6
`define CSSR_MAXPH_SIX          3'h0
`define CSSR_MAXPH_FOUR         3'h1
`define CSSR_MAXPH_THREE        3'h2
`define CSSR_MAXPH_TWO          3'h3
`define CSSR_MAXPH_ERR          3'h7

// startup strap capture window length in clock cycles
`define CSSR_INIT_CYCLES        4'h8

`endif

// [hw/cssr_strap_latch.v]
// strap capture at startup initialization
`timescale 1ns/1ns
`default_nettype none
`include "cssr_defs.vh"

module cssr_strap_latch (
   // clock and control
   input  wire       clk,
   input  wire       rst,
   input  wire       ce,
   // raw strap levels
   input  wire [1:0] pos_in,
   input  wire       swmode_in,
   input  wire       prot_in,
   input  wire       outstyle_in,
   input  wire [4:0] phase_drive_in,
   // latched configuration
   output reg  [1:0] pos_r,
   output reg        swmode_r,
   output reg        prot_r,
   output reg        outstyle_r,
   output reg  [2:0] maxph_r,
   output reg        init_done_r
);

   reg  [3:0] init_cnt_r;
   reg  [2:0] maxph_nxt;

   // maximum phase decode; a strapped first or second output is an error
   always @* begin
      if (phase_drive_in[0] || phase_drive_in[1])
         maxph_nxt = `CSSR_MAXPH_ERR;
      else if (phase_drive_in[2])
         maxph_nxt = `CSSR_MAXPH_TWO;
      else if (phase_drive_in[3])
         maxph_nxt = `CSSR_MAXPH_THREE;
      else if (phase_drive_in[4])
         maxph_nxt = `CSSR_MAXPH_FOUR;
      else
         maxph_nxt = `CSSR_MAXPH_SIX;
   end

   // straps are sampled on every cycle of the init window, frozen after it;
   // resampling the whole window lets the last sample win over settling pins
   always @(posedge clk) begin
      if (rst) begin
         init_cnt_r  <= 4'h0;
         init_done_r <= 1'b0;
         pos_r       <= 2'h0;
         swmode_r    <= 1'b0;
         prot_r      <= 1'b0;
         outstyle_r  <= 1'b0;
         maxph_r     <= 3'h0;
      end else if (ce && !init_done_r) begin
         pos_r      <= pos_in;
         swmode_r   <= swmode_in;
         prot_r     <= prot_in;
         outstyle_r <= outstyle_in;
         maxph_r    <= maxph_nxt;
         init_cnt_r <= init_cnt_r + 4'h1;
         if (init_cnt_r == `CSSR_INIT_CYCLES - 4'h1)
            init_done_r <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [hw/cssr_phase_count.v]
// operating phase count encoder
`timescale 1ns/1ns
`default_nettype none
`include "cssr_defs.vh"

module cssr_phase_count (
   // requested active phases from the converter core
   input  wire [2:0] active_sel,
   // encoded operating phase count
   output reg  [2:0] opph_code
);

   // only the four assigned codes can ever come out
   always @* begin
      case (active_sel)
         3'h0:    opph_code = `CSSR_OPPH_SIX;
         3'h1:    opph_code = `CSSR_OPPH_FOUR;
         3'h2:    opph_code = `CSSR_OPPH_THREE;
         3'h3:    opph_code = `CSSR_OPPH_TWO;
         default: opph_code = `CSSR_OPPH_SIX;
      endcase
   end

endmodule
`default_nettype wire

// [hw/cssr_status_regs.v]
// converter system status registers: strap-derived and live status bytes
// Functional notes
// - config bit 0 follows the direction pin, 0 step-down, 1 step-up.
// - bits 2:1 give the position strap latched at startup.
// - bit 3 gives switching mode strap, 0 diode emulation, 1 forced PWM.
// - bit 4 gives protection strap, 0 latch-off, 1 hiccup.
// - bit 5 gives output style strap, 0 two-level, 1 three-level.
// - bit 7 reads 1 once PWM outputs are ready, else 0.
// - slaves always read 0 in the output ready bit.
// - phase bit 0 follows shed pin, 0 shedding enabled, 1 disabled.
// - slaves always report shedding disabled, value 1.
// - bits 3:1 give operating phase count using only assigned codes.
// - bits 6:4 give maximum phase count latched from phase straps.
// - first or second phase output strapped high reports 111.
`timescale 1ns/1ns
`default_nettype none
`include "cssr_defs.vh"

module cssr_status_regs (
   // clock, reset, enable
   input  wire       CLK,
   input  wire       RST,
   input  wire       CE,
   // live pins
   input  wire       DIRECTION_SELECT_PIN,
   input  wire       PHASE_SHED_CONTROL_PIN,
   input  wire       PWM_READY,
   input  wire [2:0] ACTIVE_PHASE_SEL,
   // startup straps
   input  wire [1:0] POSITION_STRAP,
   input  wire       SWITCH_MODE_STRAP,
   input  wire       PROTECT_MODE_STRAP,
   input  wire       OUTPUT_STYLE_STRAP,
   input  wire [4:0] PHASE_DRIVE_STRAP,
   // register access from the management port
   input  wire [7:0] REG_ADDR,
   input  wire       REG_RD,
   input  wire       REG_WR,
   input  wire [7:0] REG_WDATA,
   // register answer
   output reg  [7:0] REG_RDATA,
   output reg        REG_HIT,
   output wire       INIT_DONE
);

   wire [1:0] pos_r;
   wire       swmode_r;
   wire       prot_r;
   wire       outstyle_r;
   wire [2:0] maxph_r;
   wire       init_done_r;
   wire [2:0] opph_code;
   wire       is_slave;
   reg  [7:0] conv_cfg_r;
   reg  [7:0] phase_cfg_r;
   reg  [7:0] conv_cfg_nxt;
   reg  [7:0] phase_cfg_nxt;
   reg  [7:0] rdata_nxt;
   reg        hit_nxt;

   // startup strap capture
   cssr_strap_latch u_straps (
      .clk            (CLK),
      .rst            (RST),
      .ce             (CE),
      .pos_in         (POSITION_STRAP),
      .swmode_in      (SWITCH_MODE_STRAP),
      .prot_in        (PROTECT_MODE_STRAP),
      .outstyle_in    (OUTPUT_STYLE_STRAP),
      .phase_drive_in (PHASE_DRIVE_STRAP),
      .pos_r          (pos_r),
      .swmode_r       (swmode_r),
      .prot_r         (prot_r),
      .outstyle_r     (outstyle_r),
      .maxph_r        (maxph_r),
      .init_done_r    (init_done_r)
   );

   // operating phase count encoder
   cssr_phase_count u_phcnt (
      .active_sel (ACTIVE_PHASE_SEL),
      .opph_code  (opph_code)
   );

   assign INIT_DONE = init_done_r;
   assign is_slave  = (pos_r != `CSSR_POS_MASTER);

   // next register images; the protection bit is reported even though a host
   // using per-fault responses disregards it
   always @* begin
      conv_cfg_nxt = `CSSR_RST_CONV_CFG;
      conv_cfg_nxt[`CSSR_CONV_DIR_BIT]       = DIRECTION_SELECT_PIN;
      conv_cfg_nxt[`CSSR_POS_HI:`CSSR_POS_LO] = pos_r;
      conv_cfg_nxt[`CSSR_SWMODE_BIT]         = swmode_r;
      conv_cfg_nxt[`CSSR_PROT_BIT]           = prot_r;
      conv_cfg_nxt[`CSSR_OUTSTYLE_BIT]       = outstyle_r;
      conv_cfg_nxt[`CSSR_CONV_RSVD_BIT]      = 1'b0;
      // slaves do not own the driver enable, so never ready
      conv_cfg_nxt[`CSSR_READY_BIT] = PWM_READY && !is_slave;
      phase_cfg_nxt = `CSSR_RST_PHASE_CFG;
      // master owns phase dropping; slaves show it disabled
      phase_cfg_nxt[`CSSR_SHED_BIT] = PHASE_SHED_CONTROL_PIN || is_slave;
      phase_cfg_nxt[`CSSR_OPPH_HI:`CSSR_OPPH_LO]   = opph_code;
      phase_cfg_nxt[`CSSR_MAXPH_HI:`CSSR_MAXPH_LO] = maxph_r;
      phase_cfg_nxt[`CSSR_PHASE_RSVD_BIT] = 1'b0;
   end

   // status images refresh each enabled cycle; register writes are ignored
   // so software cannot disturb them
   always @(posedge CLK) begin
      if (RST) begin
         conv_cfg_r  <= `CSSR_RST_CONV_CFG;
         phase_cfg_r <= `CSSR_RST_PHASE_CFG;
      end else if (CE) begin
         conv_cfg_r  <= conv_cfg_nxt;
         phase_cfg_r <= phase_cfg_nxt;
      end
   end

   // read decode; unmapped offsets answer zero with no hit
   always @* begin
      rdata_nxt = 8'h00;
      hit_nxt   = 1'b0;
      case (REG_ADDR)
         `CSSR_OFS_CONV_CFG: begin
            rdata_nxt = conv_cfg_r;
            hit_nxt   = 1'b1;
         end
         `CSSR_OFS_PHASE_CFG: begin
            rdata_nxt = phase_cfg_r;
            hit_nxt   = 1'b1;
         end
         default: begin
            rdata_nxt = 8'h00;
            hit_nxt   = 1'b0;
         end
      endcase
   end

   // registered read answer, one cycle after the read strobe
   always @(posedge CLK) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
         REG_HIT   <= 1'b0;
      end else if (CE) begin
         if (REG_RD) begin
            REG_RDATA <= rdata_nxt;
            REG_HIT   <= hit_nxt;
         end else if (REG_WR) begin
            // a write to either status byte is accepted but changes nothing
            REG_RDATA <= REG_RDATA;
            REG_HIT   <= hit_nxt && (REG_WDATA == REG_WDATA);
         end else begin
            REG_HIT   <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// [tb/cssr_host.sv]
// host model on the management port of the status registers
`timescale 1ns/1ns
`default_nettype none
module cssr_host (
   // bus clock
   input  wire logic       clk,
   // access strobes toward the device
   output var  logic [7:0] addr,
   output var  logic       rd,
   output var  logic       wr,
   output var  logic [7:0] wdata,
   // device answer
   input  wire logic [7:0] rdata,
   input  wire logic       hit
);
   logic per_fault = 1'b0; // this host keeps the strap protection mode

   initial begin
      addr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 8'h00;
   end

   // one access: strobe held up to its taking edge, answer read 1 ns after that same edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q, output logic h);
      @(posedge clk);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      addr <= ~a; // idle address never repeats the last one
      wdata <= ~d;
      #1;
      q = (per_fault && a == 8'hDC) ? rdata & 8'hEF : rdata;
      h = hit;
   endtask
endmodule
`default_nettype wire

// [tb/cssr_status_regs_properties.sv]
// port-level checker for the status register pair
`timescale 1ns/1ns
`default_nettype none
module cssr_status_regs_properties (
   // clock and control
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       CE,
   // live pins and straps
   input  wire logic       DIRECTION_SELECT_PIN,
   input  wire logic       PHASE_SHED_CONTROL_PIN,
   input  wire logic       PWM_READY,
   input  wire logic [1:0] POSITION_STRAP,
   // register access
   input  wire logic [7:0] REG_ADDR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_RDATA,
   input  wire logic       INIT_DONE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // taken reads after the strap window; straps only change under reset
   logic rd_c;
   logic rd_p;
   logic sl;
   assign rd_c = CE && REG_RD && REG_ADDR == 8'hDC && INIT_DONE;
   assign rd_p = CE && REG_RD && REG_ADDR == 8'hDD && INIT_DONE;
   assign sl = POSITION_STRAP != 2'h0;

   chk_dir_follow: assert property (rd_c |=> REG_RDATA[0] == $past(DIRECTION_SELECT_PIN, 2))
      else $error("direction bit off pin");
   chk_pos_latched: assert property (rd_c |=> REG_RDATA[2:1] == $past(POSITION_STRAP))
      else $error("position field wrong");
   chk_ready_master: assert property (rd_c && !sl |=> REG_RDATA[7] == $past(PWM_READY, 2))
      else $error("ready bit off core");
   chk_ready_slave: assert property (rd_c && sl |=> !REG_RDATA[7])
      else $error("slave ready bit set");
   chk_shed_master: assert property (rd_p && !sl |=> REG_RDATA[0] == $past(PHASE_SHED_CONTROL_PIN, 2))
      else $error("shed bit off pin");
   chk_shed_slave: assert property (rd_p && sl |=> REG_RDATA[0])
      else $error("slave shed bit clear");
   chk_opph_codes: assert property (rd_p |=> REG_RDATA[3:1] inside {3'h7, 3'h5, 3'h3, 3'h6})
      else $error("unassigned operating code");
   chk_maxph_codes: assert property (rd_p |=> !(REG_RDATA[6:4] inside {3'h4, 3'h5, 3'h6}))
      else $error("unassigned maximum code");
   chk_rsvd_zero: assert property ((rd_c |=> !REG_RDATA[6]) and (rd_p |=> !REG_RDATA[7]))
      else $error("reserved bit set");
endmodule
bind cssr_status_regs cssr_status_regs_properties u_chk (.CLK(CLK), .RST(RST), .CE(CE),
   .DIRECTION_SELECT_PIN(DIRECTION_SELECT_PIN), .PHASE_SHED_CONTROL_PIN(PHASE_SHED_CONTROL_PIN),
   .PWM_READY(PWM_READY), .POSITION_STRAP(POSITION_STRAP), .REG_ADDR(REG_ADDR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .INIT_DONE(INIT_DONE));
`default_nettype wire

// [tb/cssr_status_regs_tb.sv]
// self-checking bench for the status register pair
`timescale 1ns/1ns
`default_nettype none
module cssr_status_regs_tb;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       dir = 1'b0;
   logic       shed = 1'b0;
   logic       rdy = 1'b1;
   logic       ce = 1'b1;
   logic [2:0] sel = 3'h0;
   logic [1:0] pos = 2'h0;
   logic [2:0] mode = 3'h5; // output style, protection, switching
   logic [4:0] drv = 5'h00;
   logic [7:0] addr, wdata, rdata, q;
   logic       rd, wr, hit, idone, h;
   logic [2:0] opc [4] = '{3'h7, 3'h5, 3'h3, 3'h6};
   logic [4:0] drv_tab [5] = '{5'h10, 5'h08, 5'h04, 5'h01, 5'h12};
   logic [2:0] max_tab [5] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h7};
   int         num_errors = 0;
   int         check_count = 0;

   always #5 clk = ~clk;

   // device and host
   cssr_status_regs dut (.CLK(clk), .RST(rst), .CE(ce), .DIRECTION_SELECT_PIN(dir),
      .PHASE_SHED_CONTROL_PIN(shed), .PWM_READY(rdy), .ACTIVE_PHASE_SEL(sel),
      .POSITION_STRAP(pos), .SWITCH_MODE_STRAP(mode[0]), .PROTECT_MODE_STRAP(mode[1]),
      .OUTPUT_STYLE_STRAP(mode[2]), .PHASE_DRIVE_STRAP(drv), .REG_ADDR(addr), .REG_RD(rd),
      .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit), .INIT_DONE(idone));
   cssr_host host (.clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata),
      .hit(hit));

   task automatic print_verdict;
      if (num_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // read with data and hit expectations; only the two offsets are mapped
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.xfer(a, 1'b0, 8'h00, q, h);
      check("read data", exp, q);
      check("hit", {7'h00, a == 8'hDC || a == 8'hDD}, {7'h00, h});
   endtask

   // reset for 10 cycles, then a bounded wait for the strap window to close
   task automatic boot;
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 20 && idone !== 1'b1; i++) @(posedge clk);
      check("init done", 8'h01, {7'h00, idone});
      if (idone !== 1'b1) print_verdict();
   endtask

   initial begin
      boot();
      rd_chk(8'hDC, 8'hA8);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         sel <= i[2:0];
         dir <= i[0];
         shed <= i[1];
         rdy <= i[0];
         rd_chk(8'hDD, {4'h0, opc[i], i[1]});
         rd_chk(8'hDC, {i[0], 6'h14, i[0]});
      end
      host.xfer(8'hDC, 1'b1, 8'hFF, q, h);
      check("write hit", 8'h01, {7'h00, h});
      rd_chk(8'hDC, 8'hA9);
      host.xfer(8'hDD, 1'b1, 8'hFF, q, h);
      check("write hit", 8'h01, {7'h00, h});
      rd_chk(8'hDD, 8'h0D);
      rd_chk(8'hDE, 8'h00);
      // enable low: the read is not taken and the pin change waits for the enable
      @(posedge clk);
      ce <= 1'b0;
      dir <= 1'b0;
      host.xfer(8'hDC, 1'b0, 8'h00, q, h);
      check("frozen data", 8'h00, q);
      check("frozen hit", 8'h00, {7'h00, h});
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(8'hDC, 8'hA8);
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         mode <= 3'h2;
         shed <= 1'b0; // pin says shedding enabled, a slave must still show 1
         drv <= drv_tab[k];
         pos <= 2'(k % 3 + 1);
         boot();
         rd_chk(8'hDC, {5'h02, pos, 1'b0});
         rd_chk(8'hDD, {1'b0, max_tab[k], 3'h6, 1'b1});
      end
      print_verdict();
   end
endmodule
`default_nettype wire
